// [logic/epwm_pkg.sv]
// Shared constants for the enhanced PWM restart, delay and steering block
package epwm_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets on APB
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_RESTART  = 8'h00;  // Restart and delay control
    localparam logic [7:0] ADDR_STEER    = 8'h04;  // Output steering control
    localparam logic [7:0] ADDR_MODE     = 8'h08;  // Polarity, function, configuration
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;  // Shutdown event status
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;  // Sticky events, read clears
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;  // Interrupt mask
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RSEN_BIT   = 7;                 // Auto restart enable
    localparam int SYNC_BIT   = 4;                 // Steering sync
    localparam int FUNC_LSB   = 2;                 // Channel function select
    localparam int CFG_LSB    = 4;                 // Output configuration select
    localparam int IRQ_SHUT   = 0;                 // Shutdown entered event
    localparam int IRQ_RESUME = 1;                 // Auto restart event
    // ------------------------------------------------------------------
    // Values after reset and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] RESTART_RST = 8'h00;
    localparam logic [4:0] STEER_RST   = 5'h01;    // Only output A steered
    localparam logic [5:0] MODE_RST    = 6'h00;
    localparam logic [1:0] MASK_RST    = 2'h0;
    localparam logic [1:0] FUNC_PWM    = 2'h3;     // Function code for PWM
    localparam logic [1:0] CFG_SINGLE  = 2'h0;     // Single output configuration
    // ------------------------------------------------------------------
    // Timing: one instruction cycle is four oscillator periods
    // ------------------------------------------------------------------
    localparam int         TOSC_NS    = 10;
    localparam int         TCY_NS     = 4 * TOSC_NS;
    localparam logic [1:0] TCY_LAST   = 2'((TCY_NS / TOSC_NS) - 1);
endpackage : epwm_pkg

// [logic/epwm_link_if.sv]
// Signals between the control top and its delay and steering units
`timescale 1ns/100ps
interface epwm_link_if;
    logic       ce;            // Clock enable
    logic       tick;          // Instruction cycle boundary pulse
    logic       period_start;  // Start of PWM period pulse
    logic       raw;           // Scheduled PWM waveform
    logic [6:0] dc;            // Dead band delay count
    logic       dly;           // Delayed PWM waveform
    logic       shutdown;      // Outputs held in shutdown
    logic       mode_ok;       // Steering mode selected
    logic       sync;          // Steering sync
    logic [1:0] pol;           // Output polarity select
    logic [3:0] steer_req;     // Steering enables as written
    logic [3:0] port_data;     // Port pin levels
    logic [3:0] pins;          // Pin levels
    logic [3:0] sel;           // Pins driven by the PWM
    modport top (output ce, tick, period_start, raw, dc, shutdown, mode_ok, sync, pol,
                 output steer_req, port_data, input dly, pins, sel);
    modport dband (input ce, raw, dc, output dly);
    modport str (input ce, tick, period_start, dly, shutdown, mode_ok, sync, pol,
                 input steer_req, port_data, output pins, sel);
endinterface : epwm_link_if

// [logic/epwm_deadband.sv]
// Delays the active edge of the PWM by a count of instruction cycles
`timescale 1ns/100ps
module epwm_deadband (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Link to top
    epwm_link_if.dband lnk
);
    // State of the delay unit
    typedef struct packed {
        logic [8:0] cnt;     // Clocks left before going active
        logic       out;     // Delayed waveform
        logic       raw_d;   // Previous raw level
    } epwm_dly_type;
    epwm_dly_type st_r, st_nxt;

    // Rise starts the count, fall ends the pulse at once
    always_comb begin
        st_nxt       = st_r;
        st_nxt.raw_d = lnk.raw;
        if (!lnk.raw) begin
            st_nxt.out = 1'b0;
            st_nxt.cnt = 9'h000;
        end else if (!st_r.raw_d) begin
            st_nxt.cnt = {lnk.dc, 2'h0};            // [RULE3]
            st_nxt.out = (lnk.dc == 7'h00);
        end else if (st_r.cnt != 9'h000) begin
            st_nxt.cnt = st_r.cnt - 9'h001;
            st_nxt.out = (st_r.cnt == 9'h001);
        end
    end

    // Registers, frozen while the clock enable is low
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) st_r <= '0;
        else if (lnk.ce) st_r <= st_nxt;
    end

    assign lnk.dly = st_r.out;

    // Helper: clocks since the raw rise was seen
    logic [9:0] since_r;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) since_r <= 10'h000;
        else if (lnk.ce) since_r <= (lnk.raw && !st_r.raw_d) ? 10'h000 : since_r + 10'h001;
    end

    active_delay_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE3]
        $rose(st_r.out) && $stable(lnk.dc) |-> since_r == {1'b0, lnk.dc, 2'h0})
        else $error("active edge not delayed by the programmed count");
endmodule : epwm_deadband

// [logic/epwm_steer.sv]
// Steers the delayed PWM onto four pins with polarity and port fallback
`timescale 1ns/100ps
module epwm_steer (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Link to top
    epwm_link_if.str  lnk
);
    // State of the steering unit
    typedef struct packed {
        logic [3:0] en;      // Steering enables in effect
        logic [3:0] pins;    // Pin levels
        logic [3:0] sel;     // Pins under PWM control
    } epwm_str_type;
    epwm_str_type st_r, st_nxt;
    logic [3:0]   pin_val;   // PWM level per pin
    logic         upd;       // Steering update moment

    // Per pin level: A and C follow polarity bit 1, B and D bit 0
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pin
            logic low;
            assign low        = lnk.pol[(g % 2 == 0) ? 1 : 0];
            assign pin_val[g] = lnk.shutdown ? low : (lnk.dly ^ low);  // [RULE6]
        end
    endgenerate

    // Update at period start when synced, else at the instruction edge
    assign upd = lnk.sync ? lnk.period_start : lnk.tick;      // [RULE4] [RULE5]

    always_comb begin
        st_nxt      = st_r;
        if (upd) st_nxt.en = lnk.steer_req;
        st_nxt.sel  = lnk.mode_ok ? st_r.en : 4'h0;             // [RULE8]
        st_nxt.pins = (st_nxt.sel & pin_val) | (~st_nxt.sel & lnk.port_data); // [RULE7]
    end

    // Registers, frozen while the clock enable is low
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) st_r <= '{en: epwm_pkg::STEER_RST[3:0], pins: 4'h0, sel: 4'h0};
        else if (lnk.ce) st_r <= st_nxt;
    end

    assign lnk.pins = st_r.pins;
    assign lnk.sel  = st_r.sel;

    sync_period_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE4]
        $changed(st_r.en) && $past(lnk.sync) |-> $past(lnk.period_start))
        else $error("steering changed outside period start");
    async_update_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE5]
        $past(lnk.ce && !lnk.sync && lnk.tick) |-> st_r.en == $past(lnk.steer_req))
        else $error("steering not applied at instruction edge");
    pwm_on_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE6]
        $past(lnk.ce && lnk.mode_ok && st_r.en[1] && !lnk.shutdown)
        |-> st_r.pins[1] == $past(lnk.dly ^ lnk.pol[0]))
        else $error("pin B does not carry the PWM");
    port_on_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE7]
        $past(lnk.ce && !st_r.en[2]) |-> st_r.pins[2] == $past(lnk.port_data[2]) && !st_r.sel[2])
        else $error("pin C not released to port");
    mode_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE8]
        $past(lnk.ce && !lnk.mode_ok) |-> st_r.sel == 4'h0)
        else $error("steering active outside steering mode");
endmodule : epwm_steer

// [logic/epwm_top.sv]
// Enhanced PWM channel: restart, dead band delay and steering over APB
// Operation
// RULE1 - Restart enabled: status clears when shutdown ends
// RULE2 - Restart disabled: shutdown holds until software clears
// RULE3 - Active edge delayed by count instruction cycles
// RULE4 - Sync set: steering changes at period start
// RULE5 - Sync clear: steering changes at instruction edge
// RULE6 - Enabled pin carries PWM with selected polarity
// RULE7 - Disabled pin returns to port control
// RULE8 - Steering only in PWM single output mode
// RULE9 - Steering bits seven to five read zero
// RULE10 - Reset clears controls, enables output A only
`timescale 1ns/100ps
module epwm_top (
    // Clock, reset, enable
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // PWM time base and shutdown
    input  wire logic        pwm_raw_i,
    input  wire logic        period_start_i,
    input  wire logic        shutdown_req_i,
    // Port pins
    input  wire logic [3:0]  port_data_i,
    output logic      [3:0]  pwm_out_o,
    output logic      [3:0]  pwm_drive_o,
    // Status and interrupt
    output logic             shutdown_o,
    output logic             irq_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  restart;   // Restart enable and delay count
        logic [4:0]  steer;     // Sync and steering enables
        logic [5:0]  mode;      // Configuration, function, polarity
        logic        ase;       // Shutdown event status
        logic [1:0]  irq_stat;  // Sticky events
        logic [1:0]  irq_mask;  // Event mask
        logic        sd_s1;     // Shutdown request, first stage
        logic        sd_s2;     // Shutdown request, second stage
        logic [1:0]  div;       // Oscillator period within cycle
        logic        tick;      // Instruction boundary pulse
        logic        pready;    // APB ready
        logic        pslverr;   // APB error
        logic [31:0] prdata;    // APB read data
        logic        irq;       // Interrupt level
    } epwm_st_type;

    epwm_st_type st_r;        // Registered state
    epwm_st_type st_nxt;      // Next state
    logic        acc;         // APB access phase completes
    logic        wr;          // Write completes
    logic        rd;          // Read completes
    logic        setup;       // APB setup cycle
    logic        mapped;      // Address decodes
    logic [31:0] rdata;       // Read mux
    logic        sd;          // Synchronised shutdown request
    logic        mode_ok;     // Steering mode active

    epwm_link_if lnk ();

    // ------------------------------------------------------------------
    // Sub units
    // ------------------------------------------------------------------
    epwm_deadband u_dly (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .lnk       (lnk.dband)
    );

    epwm_steer u_str (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .lnk       (lnk.str)
    );

    // Drive the link
    assign lnk.ce           = ce_i;
    assign lnk.tick         = st_r.tick;
    assign lnk.period_start = period_start_i;
    assign lnk.raw          = pwm_raw_i;
    assign lnk.dc           = st_r.restart[6:0];
    assign lnk.shutdown     = st_r.ase;
    assign lnk.mode_ok      = mode_ok;
    assign lnk.sync         = st_r.steer[epwm_pkg::SYNC_BIT];
    assign lnk.pol          = st_r.mode[1:0];
    assign lnk.steer_req    = st_r.steer[3:0];
    assign lnk.port_data    = port_data_i;

    // Steering only with PWM function and single output configuration
    assign mode_ok = (st_r.mode[epwm_pkg::FUNC_LSB +: 2] == epwm_pkg::FUNC_PWM)  // [RULE8]
                  && (st_r.mode[epwm_pkg::CFG_LSB +: 2] == epwm_pkg::CFG_SINGLE);

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign setup = psel_i && !penable_i;
    assign acc   = psel_i && penable_i && st_r.pready;
    assign wr    = acc && pwrite_i;
    assign rd    = acc && !pwrite_i;
    assign sd    = st_r.sd_s2;

    // Read mux, unused bits zero
    always_comb begin
        rdata  = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr_i)
            epwm_pkg::ADDR_RESTART:  rdata[7:0] = st_r.restart;
            epwm_pkg::ADDR_STEER:    rdata[4:0] = st_r.steer;     // [RULE9]
            epwm_pkg::ADDR_MODE:     rdata[5:0] = st_r.mode;
            epwm_pkg::ADDR_STATUS:   rdata[0]   = st_r.ase;
            epwm_pkg::ADDR_IRQ_STAT: rdata[1:0] = st_r.irq_stat;
            epwm_pkg::ADDR_IRQ_MASK: rdata[1:0] = st_r.irq_mask;
            default:                 mapped     = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Shutdown request synchroniser
        st_nxt.sd_s1 = shutdown_req_i;
        st_nxt.sd_s2 = st_r.sd_s1;
        // Instruction cycle divider
        st_nxt.div  = (st_r.div == epwm_pkg::TCY_LAST) ? 2'h0 : st_r.div + 2'h1;
        st_nxt.tick = (st_r.div == epwm_pkg::TCY_LAST);
        // APB answer one cycle after setup
        st_nxt.pready  = setup;
        st_nxt.pslverr = setup && !mapped;
        if (setup) begin
            st_nxt.prdata = rdata;
        end
        // Register writes
        if (wr) begin
            case (paddr_i)
                epwm_pkg::ADDR_RESTART:  st_nxt.restart  = pwdata_i[7:0];
                epwm_pkg::ADDR_STEER:    st_nxt.steer    = pwdata_i[4:0];  // [RULE9]
                epwm_pkg::ADDR_MODE:     st_nxt.mode     = pwdata_i[5:0];
                epwm_pkg::ADDR_STATUS:   st_nxt.ase      = pwdata_i[0];    // [RULE2]
                epwm_pkg::ADDR_IRQ_MASK: st_nxt.irq_mask = pwdata_i[1:0];
                default:                 st_nxt.ase      = st_r.ase;
            endcase
        end
        // Reading the event register clears it
        // Only the events returned are cleared, one arriving meanwhile stays
        if (rd && paddr_i == epwm_pkg::ADDR_IRQ_STAT) begin
            st_nxt.irq_stat = st_r.irq_stat & ~st_r.prdata[1:0];
        end
        // Automatic clear once the condition has gone
        if (st_r.ase && st_r.restart[epwm_pkg::RSEN_BIT] && !sd) begin
            st_nxt.ase = 1'b0;                                       // [RULE1]
            st_nxt.irq_stat[epwm_pkg::IRQ_RESUME] = 1'b1;
        end
        // A live shutdown request wins over any clear
        if (sd) begin
            st_nxt.ase = 1'b1;
            if (!st_r.ase) begin
                st_nxt.irq_stat[epwm_pkg::IRQ_SHUT] = 1'b1;
            end
        end
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    // ------------------------------------------------------------------
    // Registers, frozen while the clock enable is low
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r          <= '0;
            st_r.restart  <= epwm_pkg::RESTART_RST;                 // [RULE10]
            st_r.steer    <= epwm_pkg::STEER_RST;
            st_r.mode     <= epwm_pkg::MODE_RST;
            st_r.irq_mask <= epwm_pkg::MASK_RST;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata_o    = st_r.prdata;
    assign pready_o    = st_r.pready;
    assign pslverr_o   = st_r.pslverr;
    assign pwm_out_o   = lnk.pins;
    assign pwm_drive_o = lnk.sel;
    assign shutdown_o  = st_r.ase;
    assign irq_o       = st_r.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    auto_restart_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE1]
        ce_i && st_r.ase && st_r.restart[7] && !sd |=> !st_r.ase)
        else $error("status not cleared after shutdown ended");

    hold_shutdown_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE2]
        ce_i && st_r.ase && !st_r.restart[7] && !(wr && paddr_i == epwm_pkg::ADDR_STATUS)
        |=> st_r.ase)
        else $error("shutdown released without software");

    shut_pins_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE6]
        st_r.ase && $past(st_r.ase) && ce_i && $past(ce_i)
        && st_r.mode[1:0] == 2'h0 |=> (pwm_out_o & pwm_drive_o) == 4'h0)
        else $error("steered pin active during shutdown");

    steer_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE9]
        pready_o && $past(paddr_i == epwm_pkg::ADDR_STEER && setup && ce_i)
        |-> prdata_o[7:5] == 3'h0)
        else $error("unimplemented steering bits read nonzero");

    reset_values_a: assert property (@(posedge ref_clk_i) // [RULE10]
        $fell(rst_i) |-> st_r.restart == 8'h00 && st_r.steer == 5'h01)
        else $error("wrong control values after reset");

    irq_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        irq_o == |(st_r.irq_stat & st_r.irq_mask))
        else $error("interrupt level disagrees with status and mask");

    tick_rate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ce_i && st_r.tick ##1 ce_i [*3] |-> !st_r.tick)
        else $error("instruction tick too frequent");
endmodule : epwm_top

// [verification/epwm_load_model.sv]
// Far side model: PWM time base and port pin source
`timescale 1ns/100ps
module epwm_load_model (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Time base setup
    input  wire logic [7:0] period_i,
    input  wire logic [7:0] duty_i,
    input  wire logic [3:0] port_val_i,
    // Toward the channel
    output logic            raw_o,
    output logic            pstart_o,
    output logic      [3:0] port_data_o
);
    // ------------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------------
    logic [7:0] cnt_r;  // Position in period

    // Wraps each period, raw high for duty clocks after start
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r    <= 8'h00;
            raw_o    <= 1'b0;
            pstart_o <= 1'b0;
        end else begin
            cnt_r    <= (cnt_r == period_i - 8'h01) ? 8'h00 : cnt_r + 8'h01;
            pstart_o <= (cnt_r == period_i - 8'h01);
            raw_o    <= (cnt_r == period_i - 8'h01) || (cnt_r + 8'h01 < duty_i);
        end
    end

    // Port latch levels for pins not carrying the PWM
    assign port_data_o = port_val_i;
endmodule : epwm_load_model

// [verification/epwm_top_tb.sv]
// Self-checking bench for the enhanced PWM channel
`timescale 1ns/100ps
module epwm_top_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        ref_clk_i, rst_i, psel_i, penable_i, pwrite_i, shut_req;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        pready_o, pslverr_o, raw, pstart, shutdown_o, irq_o, err, ce;
    logic [3:0]  port_data, pwm_out_o, pwm_drive_o;
    int          n_mismatch, samples_checked, n, dcv;

    epwm_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pwm_raw_i(raw),
        .period_start_i(pstart), .shutdown_req_i(shut_req), .port_data_i(port_data),
        .pwm_out_o(pwm_out_o), .pwm_drive_o(pwm_drive_o), .shutdown_o(shutdown_o),
        .irq_o(irq_o));
    epwm_load_model LOAD (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .period_i(8'h40),
        .duty_i(8'h20), .port_val_i(4'hA), .raw_o(raw), .pstart_o(pstart),
        .port_data_o(port_data));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Verdict and end of run
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 16) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : apb

    // Read a register and compare
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk

    // Wait a number of clocks
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask : cyc

    // A wait that used up its bound ends the run
    task automatic tmo(input int lim);
        if (n >= lim) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : tmo

    // ------------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        {psel_i, penable_i, pwrite_i, shut_req, paddr_i, pwdata_i} = '0;
        ce = 1'b1;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdchk("restart rst", epwm_pkg::ADDR_RESTART, 32'h00);
        rdchk("steer rst", epwm_pkg::ADDR_STEER, 32'h01);
        rdchk("mask rst", epwm_pkg::ADDR_IRQ_MASK, 32'h00);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, epwm_pkg::ADDR_STEER, 32'hFF);
        rdchk("steer high bits", epwm_pkg::ADDR_STEER, 32'h1F);
        apb(1'b1, epwm_pkg::ADDR_STEER, 32'h01);
        cyc(6);
        chk("drive off mode", 32'h0, {28'h0, pwm_drive_o});
        apb(1'b1, epwm_pkg::ADDR_MODE, 32'h0C);
        cyc(6);
        chk("drive pwm mode", 32'h1, {28'h0, pwm_drive_o});
        apb(1'b1, epwm_pkg::ADDR_MODE, 32'h1C);
        cyc(6);
        chk("drive cfg off", 32'h0, {28'h0, pwm_drive_o});
        apb(1'b1, epwm_pkg::ADDR_MODE, 32'h0C);
        // Active edge delay for several counts
        for (int i = 0; i < 3; i++) begin
            dcv = (i == 0) ? 0 : (i == 1) ? 1 : 7;
            apb(1'b1, epwm_pkg::ADDR_RESTART, 32'(dcv));
            for (n = 0; n < 200 && raw !== 1'b0; n++) @(posedge ref_clk_i);
            tmo(200);
            for (n = 0; n < 200 && raw !== 1'b1; n++) @(posedge ref_clk_i);
            tmo(200);
            for (n = 0; n < 60 && pwm_out_o[0] !== 1'b1; n++) @(posedge ref_clk_i);
            chk("dead band", 32'(2 + 4 * dcv), 32'(n));
            tmo(60);
        end
        // Inverted polarity on output A
        apb(1'b1, epwm_pkg::ADDR_RESTART, 32'h00);
        apb(1'b1, epwm_pkg::ADDR_MODE, 32'h0E);
        for (n = 0; n < 200 && raw !== 1'b0; n++) @(posedge ref_clk_i);
        tmo(200);
        for (n = 0; n < 200 && raw !== 1'b1; n++) @(posedge ref_clk_i);
        tmo(200);
        cyc(10);
        chk("inverted active", 32'h0, {31'h0, pwm_out_o[0]});
        cyc(30);
        chk("inverted idle", 32'h1, {31'h0, pwm_out_o[0]});
        // Clock enable low freezes the pins across a raw rise
        ce <= 1'b0;
        cyc(1);
        rd = {28'h0, pwm_out_o};
        cyc(40);
        chk("frozen pins", rd, {28'h0, pwm_out_o});
        ce <= 1'b1;
        apb(1'b1, epwm_pkg::ADDR_MODE, 32'h0C);
        // Steering without sync
        apb(1'b1, epwm_pkg::ADDR_STEER, 32'h02);
        for (n = 0; n < 8 && pwm_drive_o !== 4'h2; n++) @(posedge ref_clk_i);
        tmo(8);
        chk("steer no sync", 32'h2, {28'h0, pwm_drive_o});
        chk("port fallback", 32'h8, {28'h0, pwm_out_o & 4'hD});
        // Steering with sync waits for period start
        for (n = 0; n < 100 && pstart !== 1'b1; n++) @(posedge ref_clk_i);
        tmo(100);
        apb(1'b1, epwm_pkg::ADDR_STEER, 32'h14);
        cyc(20);
        chk("sync hold", 32'h2, {28'h0, pwm_drive_o});
        for (n = 0; n < 100 && pstart !== 1'b1; n++) @(posedge ref_clk_i);
        tmo(100);
        cyc(3);
        chk("sync apply", 32'h4, {28'h0, pwm_drive_o});
        // Shutdown held until software clears
        apb(1'b1, epwm_pkg::ADDR_IRQ_MASK, 32'h2);
        shut_req <= 1'b1;
        for (n = 0; n < 8 && shutdown_o !== 1'b1; n++) @(posedge ref_clk_i);
        tmo(8);
        shut_req <= 1'b0;
        cyc(10);
        chk("held shutdown", 32'h1, {31'h0, shutdown_o});
        chk("masked irq", 32'h0, {31'h0, irq_o});
        rdchk("shut event", epwm_pkg::ADDR_IRQ_STAT, 32'h1);
        apb(1'b1, epwm_pkg::ADDR_STATUS, 32'h0);
        cyc(3);
        chk("sw clear", 32'h0, {31'h0, shutdown_o});
        // Automatic restart
        apb(1'b1, epwm_pkg::ADDR_RESTART, 32'h80);
        shut_req <= 1'b1;
        for (n = 0; n < 8 && shutdown_o !== 1'b1; n++) @(posedge ref_clk_i);
        tmo(8);
        shut_req <= 1'b0;
        for (n = 0; n < 8 && shutdown_o !== 1'b0; n++) @(posedge ref_clk_i);
        tmo(8);
        cyc(2);
        chk("auto clear", 32'h0, {31'h0, shutdown_o});
        chk("resume irq", 32'h1, {31'h0, irq_o});
        rdchk("both events", epwm_pkg::ADDR_IRQ_STAT, 32'h3);
        cyc(2);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        report_and_stop();
    end
endmodule : epwm_top_tb
